/* design/oad_cfg.svh */
// Constants of the operand address and decode block.
// Summary of operation
// - Direct address is page pointer (9 bits) above the 7-bit instruction offset.
// - Direct space is 512 pages of 128 words.
// - Direct offset comes from instruction bits 6 to 0.
// - Three-bit pointer picks one of eight auxiliary registers as indirect address.
// - Seven indirect updates: inc, dec, +AR0, -AR0, none, bit-reversed inc/dec.
// - Address uses current register first; update and pointer change follow.
// - Immediate operand comes from instruction field or second instruction word.
// - One following instruction may run up to 256 times; 8-bit counter.
// - Repeat counter loads from memory operand or immediate field.
// - Loaded count N makes the next instruction run N plus one times.
// - Repetitions after the first take one cycle each.
// - Prefetch overlaps execution; external operand access add_low_unsigned a cycle.
// - Most instructions take one cycle; branch, call and I/O are multicycle.
// - Decode 4-bit load/add shift field and 3-bit store shift field.
// - Decode 2-bit product shift code selecting one of four modes.
// - Decode 3-bit register field, 4-bit bit-select, 2-bit compare mode.
// - Add with shift: top 0000, shift 11:8, mode bit 7, address 6:0.
// - Upper bytes 48, 49, 4A decode high, unsigned and temp-shift add_low_unsigned.
// - Upper byte CC add_low_unsigned 8-bit unsigned low-byte constant.
// - Top 1101 with low byte 02 or 04: long add or AND, two words.
// - Upper byte 4E ANDs the low accumulator with the memory operand.
// - Operand shifts left 0 to 16 places with zero fill at the bottom.
// - Sign-extend mode picks sign fill or zero fill above the operand.
`ifndef OAD_CFG_SVH
`define OAD_CFG_SVH
`define OAD_OFS_CTRL 8'h00
`define OAD_OFS_ARP 8'h04
`define OAD_OFS_OPERAND 8'h08
`define OAD_OFS_TEMP 8'h0C
`define OAD_OFS_WORD2 8'h10
`define OAD_OFS_INSTR 8'h14
`define OAD_OFS_STATUS 8'h18
`define OAD_OFS_RESULT 8'h1C
`define OAD_OFS_DECODE 8'h20
`define OAD_OFS_AUX 8'h40
`define OAD_CTRL_SXM 9
`define OAD_CTRL_EXT 12
`define OAD_UB_ADD_HIGH_HALF 8'h48
`define OAD_UB_ADD_LOW_UNSIGNED 8'h49
`define OAD_UB_ADD_SHIFT_BY_TEMP 8'h4A
`define OAD_UB_RPT 8'h4B
`define OAD_UB_AND 8'h4E
`define OAD_UB_ADD_SHORT_CONST 8'hCC
`define OAD_UB_REPEAT_IMMEDIATE 8'hCB
`define OAD_TN_ADD 4'h0
`define OAD_TN_LONG 4'hD
`define OAD_TN_BRANCH 4'hF
`define OAD_TN_IN 4'h8
`define OAD_TN_OUT 4'hE
`define OAD_LB_ADD_LONG_CONST 8'h02
`define OAD_LB_AND_LONG_CONST 8'h04
`define OAD_MULTI_CYC 2'h2
`define OAD_HIGH_SHIFT 5'h10
`define OAD_CLK_PERIOD_NS 100
`endif

/* design/oad_pkg.sv */
// Types shared by the operand address and decode block.
package oad_pkg;
	typedef enum logic [1:0] {oad_idle, oad_exec} oad_state_t;
	typedef enum logic [2:0] {
		oad_md_none, oad_md_inc, oad_md_dec, oad_md_add0,
		oad_md_sub0, oad_md_brinc, oad_md_brdec, oad_md_none2
	} oad_ind_mode_t;
	typedef struct packed {
		logic [3:0] shift_code;
		logic [2:0] store_shift;
		logic [1:0] product_shift_code;
		logic [2:0] aux_field;
		logic [3:0] bit_select;
		logic [1:0] compare_mode_field;
	} oad_fields_t;
endpackage

/* design/oad_decode.sv */
// Instruction decode, operand address generation and repeat control over APB.
`timescale 1ns/1ps
`include "oad_cfg.svh"
module oad_decode import oad_pkg::*; #(
	parameter int AUX_COUNT = 8,
	parameter int PAGE_BITS = 9
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Operand presented to memory and ALU
	output logic [15:0] oper_addr,
	output logic oper_valid,
	output logic [31:0] alu_operand
);

	localparam int AW = $clog2(AUX_COUNT);

	// Register storage.
	logic [31:0] ctrl_reg;
	logic [AW-1:0] aux_reg_pointer;
	logic [15:0] operand_reg;
	logic [15:0] temporary_operand_reg;
	logic [15:0] word2_reg;
	logic [15:0] instr_reg;
	logic [15:0] aux_regs [AUX_COUNT];
	logic [7:0] repeat_counter;
	logic repeat_armed;
	logic repeating;
	logic [1:0] cyc_left;
	oad_state_t state;
	oad_fields_t fields_reg;

	function automatic logic [15:0] bitrev(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15-i];
		end
		return r;
	endfunction

	// Left shift with selectable upper fill; bottom is always zero.
	function automatic logic [31:0] shift_op(input logic [15:0] v, input logic [4:0] sh,
			input logic sx);
		logic [31:0] ext;
		ext = {(sx ? {16{v[15]}} : 16'h0000), v};
		return ext << sh;
	endfunction

	// Branch, call and I/O words need an extra cycle; other words are single-cycle unless an external operand adds one.
	function automatic logic multi_op(input logic [15:0] w);
		logic [3:0] top;
		top = w[15:12];
		return (top == `OAD_TN_BRANCH) || (top == `OAD_TN_IN) || (top == `OAD_TN_OUT);
	endfunction

	// True when a bus address selects auxiliary register idx.
	function automatic logic aux_hit(input logic [7:0] a, input int idx);
		return a == (`OAD_OFS_AUX + 8'(idx * 4));
	endfunction

	// APB strobes.
	logic setup;
	logic wr_acc;
	logic issue;
	logic busy;
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
	assign busy = (state != oad_idle);
	assign issue = wr_acc & (paddr == `OAD_OFS_INSTR) & ~busy;

	// Decode of the held instruction.
	logic [7:0] ub;
	logic [3:0] tn;
	logic is_long;
	logic is_rpt;
	logic is_repeat_immediate;
	logic is_memref;
	logic ind;
	oad_ind_mode_t imode;
	logic [15:0] cur_ar;
	logic [15:0] ar0;
	logic [15:0] eff_addr;
	logic sign_extend_mode;
	logic [31:0] op_val;
	assign ub = instr_reg[15:8];
	assign tn = instr_reg[15:12];
	assign is_long = (tn == `OAD_TN_LONG) &&
		(instr_reg[7:0] == `OAD_LB_ADD_LONG_CONST || instr_reg[7:0] == `OAD_LB_AND_LONG_CONST);
	assign is_rpt = (ub == `OAD_UB_RPT);
	assign is_repeat_immediate = (ub == `OAD_UB_REPEAT_IMMEDIATE);
	assign is_memref = ~instr_reg[15];
	assign ind = instr_reg[7];
	assign imode = oad_ind_mode_t'(instr_reg[6:4]);
	assign cur_ar = aux_regs[aux_reg_pointer];
	assign ar0 = aux_regs[0];
	assign sign_extend_mode = ctrl_reg[`OAD_CTRL_SXM];
	// Address is taken from the current register before any update.
	assign eff_addr = ind ? cur_ar :
		{ctrl_reg[PAGE_BITS-1:0], instr_reg[6:0]};

	always_comb begin
		op_val = shift_op(operand_reg, 5'h00, sign_extend_mode);
		if (tn == `OAD_TN_ADD) begin
			op_val = shift_op(operand_reg, {1'b0, instr_reg[11:8]}, sign_extend_mode);
		end else if (ub == `OAD_UB_ADD_HIGH_HALF) begin
			op_val = shift_op(operand_reg, `OAD_HIGH_SHIFT, sign_extend_mode);
		end else if (ub == `OAD_UB_ADD_LOW_UNSIGNED) begin
			op_val = shift_op(operand_reg, 5'h00, 1'b0);
		end else if (ub == `OAD_UB_ADD_SHIFT_BY_TEMP) begin
			op_val = shift_op(operand_reg, {1'b0, temporary_operand_reg[3:0]}, sign_extend_mode);
		end else if (ub == `OAD_UB_AND) begin
			op_val = {16'h0000, operand_reg};
		end else if (ub == `OAD_UB_ADD_SHORT_CONST) begin
			op_val = {24'h000000, instr_reg[7:0]};
		end else if (is_long) begin
			op_val = shift_op(word2_reg, {1'b0, instr_reg[11:8]}, sign_extend_mode);
		end
	end

	// Next value of the current auxiliary register after its use.
	// Bit-reversed modes add in mirrored order, so the carry runs from the top bit
	// downwards, which is the index order that a reordered transform needs.
	logic [15:0] ar_next;
	always_comb begin
		case (imode)
			oad_md_inc: ar_next = cur_ar + 16'h0001;
			oad_md_dec: ar_next = cur_ar - 16'h0001;
			oad_md_add0: ar_next = cur_ar + ar0;
			oad_md_sub0: ar_next = cur_ar - ar0;
			oad_md_brinc: ar_next = bitrev(bitrev(cur_ar) + bitrev(ar0));
			oad_md_brdec: ar_next = bitrev(bitrev(cur_ar) - bitrev(ar0));
			default: ar_next = cur_ar;
		endcase
	end

	// One iteration ends when the cycle count runs out.
	logic iter_end;
	logic more;
	assign iter_end = (state == oad_exec) && (cyc_left == 2'h0);
	assign more = repeating && (repeat_counter != 8'h00);

	// Execution sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= oad_idle;
			cyc_left <= 2'h0;
		end else begin
			case (state)
				oad_idle: begin
					if (issue) begin
						state <= oad_exec;
						// Prefetch hides the fetch; only branch/IO and an
						// external operand cost extra cycles.
						cyc_left <= multi_op(pwdata[15:0]) ? `OAD_MULTI_CYC - 2'h1 : 2'h0;
						if (ctrl_reg[`OAD_CTRL_EXT] && !pwdata[15]) begin
							cyc_left <= 2'h1;
						end
					end
				end
				oad_exec: begin
					if (cyc_left != 2'h0) begin
						cyc_left <= cyc_left - 2'h1;
					end else if (more) begin
						cyc_left <= 2'h0;
					end else begin
						state <= oad_idle;
					end
				end
				default: state <= oad_idle;
			endcase
		end
	end

	// Repeat counter: loaded with N, runs N plus one iterations.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			repeat_counter <= 8'h00;
		end else if (iter_end) begin
			if (is_rpt) begin
				repeat_counter <= operand_reg[7:0];
			end else if (is_repeat_immediate) begin
				repeat_counter <= instr_reg[7:0];
			end else if (more) begin
				repeat_counter <= repeat_counter - 8'h01;
			end
		end
	end

	// Only the word issued right after a load is repeated; the load arms the count
	// rather than starting it, so the load itself is never counted as an iteration.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			repeat_armed <= 1'b0;
			repeating <= 1'b0;
		end else begin
			if (issue && repeat_armed) begin
				repeating <= 1'b1;
				repeat_armed <= 1'b0;
			end
			if (iter_end) begin
				if (is_rpt || is_repeat_immediate) begin
					repeat_armed <= 1'b1;
				end else if (!more) begin
					repeating <= 1'b0;
				end
			end
		end
	end

	// Auxiliary registers and pointer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_reg_pointer <= '0;
			for (int i = 0; i < AUX_COUNT; i++) begin
				aux_regs[i] <= 16'h0000;
			end
		end else begin
			if (iter_end && is_memref && ind) begin
				aux_regs[aux_reg_pointer] <= ar_next;
				if (instr_reg[3]) begin
					aux_reg_pointer <= instr_reg[AW-1:0];
				end
			end else if (wr_acc && !busy) begin
				if (paddr == `OAD_OFS_ARP) begin
					aux_reg_pointer <= pwdata[AW-1:0];
				end
				for (int i = 0; i < AUX_COUNT; i++) begin
					if (aux_hit(paddr, i)) begin
						aux_regs[i] <= pwdata[15:0];
					end
				end
			end
		end
	end

	// Software-written configuration and operand registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= 32'h00000000;
			operand_reg <= 16'h0000;
			temporary_operand_reg <= 16'h0000;
			word2_reg <= 16'h0000;
			instr_reg <= 16'h0000;
		end else if (wr_acc && !busy) begin
			case (paddr)
				`OAD_OFS_CTRL: ctrl_reg <= {19'h00000, pwdata[12:0]};
				`OAD_OFS_OPERAND: operand_reg <= pwdata[15:0];
				`OAD_OFS_TEMP: temporary_operand_reg <= pwdata[15:0];
				`OAD_OFS_WORD2: word2_reg <= pwdata[15:0];
				`OAD_OFS_INSTR: instr_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Field decode of each issued word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fields_reg <= '0;
		end else if (issue) begin
			fields_reg.shift_code <= pwdata[11:8];
			fields_reg.store_shift <= pwdata[10:8];
			fields_reg.product_shift_code <= pwdata[1:0];
			fields_reg.aux_field <= pwdata[2:0];
			fields_reg.bit_select <= pwdata[11:8];
			fields_reg.compare_mode_field <= pwdata[1:0];
		end
	end

	// Operand outputs, one pulse per iteration.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oper_valid <= 1'b0;
		end else begin
			oper_valid <= iter_end;
		end
	end

	// Address and operand hold until the next iteration replaces them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oper_addr <= 16'h0000;
		end else if (iter_end) begin
			oper_addr <= is_memref ? eff_addr : 16'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alu_operand <= 32'h00000000;
		end else if (iter_end) begin
			alu_operand <= op_val;
		end
	end

	// APB answer: one access cycle, no waits.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		case (paddr)
			`OAD_OFS_CTRL: rd_mux = ctrl_reg;
			`OAD_OFS_ARP: rd_mux = {29'h0, 3'(aux_reg_pointer)};
			`OAD_OFS_OPERAND: rd_mux = {16'h0000, operand_reg};
			`OAD_OFS_TEMP: rd_mux = {16'h0000, temporary_operand_reg};
			`OAD_OFS_WORD2: rd_mux = {16'h0000, word2_reg};
			`OAD_OFS_INSTR: rd_mux = {16'h0000, instr_reg};
			`OAD_OFS_STATUS: rd_mux = {oper_addr, repeat_counter, 5'h00, repeat_armed,
				repeating, busy};
			`OAD_OFS_RESULT: rd_mux = alu_operand;
			`OAD_OFS_DECODE: rd_mux = {14'h0000, fields_reg};
			default: begin
				for (int i = 0; i < AUX_COUNT; i++) begin
					if (aux_hit(paddr, i)) begin
						rd_mux = {16'h0000, aux_regs[i]};
					end
				end
			end
		endcase
	end

	// Any byte address that is not a word of the map is refused.
	logic mapped;
	always_comb begin
		mapped = (paddr <= `OAD_OFS_DECODE) && (paddr[1:0] == 2'b00);
		for (int i = 0; i < AUX_COUNT; i++) begin
			if (aux_hit(paddr, i)) begin
				mapped = 1'b1;
			end
		end
	end

	// Ready answers every setup after exactly one access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Writes while executing are refused so operands cannot shift under it; the
	// refusal is decided at setup and also blocks the write at the access edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && (!mapped || (pwrite && busy));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

endmodule // oad_decode

/* verif/oad_decode_properties.sv */
// Port-level timing and decode checks for the operand decode block.
`timescale 1ns/1ps
`include "oad_cfg.svh"
module oad_decode_properties (
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Operand side
	input wire logic [15:0] oper_addr,
	input wire logic oper_valid,
	input wire logic [31:0] alu_operand
);
	logic [15:0] instr_reg;
	logic [12:0] ctrl_reg;
	logic wr_ok;
	logic issue;
	assign wr_ok = pready && pwrite && !pslverr;
	assign issue = wr_ok && paddr == `OAD_OFS_INSTR;
	// Shadow copies let the checks see what software loaded without peeking inside.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg <= 16'h0;
			ctrl_reg <= 13'h0;
		end else if (issue) begin
			instr_reg <= pwdata[15:0];
		end else if (wr_ok && paddr == `OAD_OFS_CTRL) begin
			ctrl_reg <= pwdata[12:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_one_wait: assert property (psel && !penable |=> pready) else $error("late ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
	a_prdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("stray read data");
	a_misaligned_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned accepted");
	a_single_cycle: assert property (issue && pwdata[15:12] == 4'h0 && !ctrl_reg[12]
		|=> !oper_valid ##1 oper_valid) else $error("add latency");
	a_branch_extra: assert property (issue && pwdata[15:12] == `OAD_TN_BRANCH
		|=> !oper_valid [*2] ##1 oper_valid) else $error("branch latency");
	a_ext_extra: assert property (issue && pwdata[15:12] == 4'h0 && ctrl_reg[12]
		|=> !oper_valid [*2] ##1 oper_valid) else $error("external latency");
	a_direct_addr: assert property (oper_valid && !instr_reg[15] && !instr_reg[7]
		|-> oper_addr == {ctrl_reg[8:0], instr_reg[6:0]}) else $error("direct address");
	a_short_const: assert property (oper_valid && instr_reg[15:8] == `OAD_UB_ADD_SHORT_CONST
		|-> alu_operand == {24'h0, instr_reg[7:0]}) else $error("short constant");
endmodule // oad_decode_properties
bind oad_decode oad_decode_properties u_oad_decode_properties (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.oper_addr(oper_addr), .oper_valid(oper_valid), .alu_operand(alu_operand));

/* verif/oad_mem_model.sv */
// Data memory stand-in that logs every operand access.
`timescale 1ns/1ps
module oad_mem_model (
	// Operand access
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] oper_addr,
	input wire logic oper_valid,
	// Observation
	output logic [15:0] access_count,
	output logic [15:0] last_addr
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_count <= 16'h0;
			last_addr <= 16'h0;
		end else if (oper_valid) begin
			access_count <= access_count + 16'h1;
			last_addr <= oper_addr;
		end
	end
endmodule // oad_mem_model

/* verif/tb_oad_decode.sv */
// Self-checking bench for the operand decode block.
`timescale 1ns/1ps
`include "oad_cfg.svh"
module tb_oad_decode;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, alu_operand, rd;
	logic pready, pslverr, oper_valid, err;
	logic [15:0] oper_addr, acc_cnt, base, op, ar, rv;
	logic [48:0] exp_q[$];
	logic [48:0] item;
	logic [8:0] page;
	logic [6:0] off;
	logic [3:0] s;
	logic [15:0] step[5] = '{16'h0, 16'h1, 16'hFFFF, 16'h10, 16'hFFF0};
	int num_errors = 0;
	int total_checks = 0;
	int seed = 32'hd66a7315;
	always #50 pclk = ~pclk;
	oad_decode u_oad_decode (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .oper_addr(oper_addr), .oper_valid(oper_valid),
		.alu_operand(alu_operand));
	oad_mem_model u_oad_mem_model (.pclk(pclk), .presetn(presetn), .oper_addr(oper_addr),
		.oper_valid(oper_valid), .access_count(acc_cnt), .last_addr());
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [15:0] ins);
		int n;
		n = 0;
		apb(1'b1, `OAD_OFS_INSTR, {16'h0, ins});
		do begin
			apb(1'b0, `OAD_OFS_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 300);
	endtask
	task automatic end_sim();
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Each executed iteration takes the oldest expectation; a cleared top bit skips it.
	always @(posedge pclk) begin
		if (oper_valid === 1'b1) begin
			item = exp_q.pop_front();
			if (item[48] !== 1'b0) begin
				check("oper_addr", {16'h0, oper_addr}, {16'h0, item[47:32]});
				check("alu_operand", alu_operand, item[31:0]);
			end
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OAD_OFS_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			page = 9'($random(seed));
			op = 16'($random(seed));
			off = 7'($random(seed));
			s = 4'(i * 5);
			apb(1'b1, `OAD_OFS_CTRL, {22'h0, i[0], page});
			apb(1'b1, `OAD_OFS_OPERAND, {16'h0, op});
			exp_q.push_back({1'b1, page, off, ({(i[0] ? {16{op[15]}} : 16'h0), op} << s)});
			run({4'h0, s, 1'b0, off});
		end
		apb(1'b0, `OAD_OFS_DECODE, 32'h0);
		check("fields", rd, {14'h0, s, s[2:0], off[1:0], off[2:0], s, off[1:0]});
		apb(1'b1, `OAD_OFS_CTRL, 32'h0);
		apb(1'b1, `OAD_OFS_AUX, 32'h10);
		for (int m = 0; m < 7; m++) begin
			ar = 16'($random(seed));
			apb(1'b1, `OAD_OFS_AUX + 8'hC, {16'h0, ar});
			apb(1'b1, `OAD_OFS_ARP, 32'h3);
			exp_q.push_back({1'b1, ar, 16'h0, op});
			run({8'h00, 1'b1, 3'(m), 4'hD});
			apb(1'b0, `OAD_OFS_AUX + 8'hC, 32'h0);
			if (m < 5) begin
				rv = ar + step[m];
			end else begin
				// Bit-reversed step: the mirror of the register zero value 16'h0010.
				rv = {<<{ar}};
				rv = (m == 5) ? rv + 16'h0800 : rv - 16'h0800;
				rv = {<<{rv}};
			end
			check("aux update", rd, {16'h0, rv});
			apb(1'b0, `OAD_OFS_ARP, 32'h0);
			check("pointer", rd, 32'h5);
		end
		exp_q.push_back({1'b1, 16'h0, 32'hA5});
		run(16'hCCA5);
		apb(1'b1, `OAD_OFS_WORD2, {16'h0, op});
		exp_q.push_back({1'b1, 16'h0, ({16'h0, op} << 3)});
		run(16'hD302);
		exp_q.push_back({1'b1, 16'h0, ({16'h0, op} << 3)});
		run(16'hD304);
		exp_q.push_back({1'b1, 16'h11, 16'h0, op});
		run(16'h4E11);
		apb(1'b1, `OAD_OFS_TEMP, 32'h5);
		apb(1'b1, `OAD_OFS_CTRL, 32'h200);
		exp_q.push_back({1'b1, 16'h12, op, 16'h0});
		run(16'h4812);
		exp_q.push_back({1'b1, 16'h13, 16'h0, op});
		run(16'h4913);
		exp_q.push_back({1'b1, 16'h14, ({{16{op[15]}}, op} << 5)});
		run(16'h4A14);
		exp_q.push_back({1'b0, 48'h0});
		run(16'hF000);
		apb(1'b1, `OAD_OFS_CTRL, 32'h1000);
		exp_q.push_back({1'b1, 16'h22, 16'h0, op});
		run(16'h0022);
		exp_q.push_back({1'b0, 48'h0});
		run(16'hCBFF);
		for (int k = 0; k < 256; k++) exp_q.push_back({1'b1, 16'h0, 32'h7});
		base = acc_cnt;
		apb(1'b1, `OAD_OFS_INSTR, 32'hCC07);
		apb(1'b1, `OAD_OFS_CTRL, 32'h0);
		check("busy refusal", {31'h0, err}, 32'h1);
		repeat (255) @(posedge pclk);
		check("repeat runs", {16'h0, acc_cnt - base}, 32'd256);
		apb(1'b0, `OAD_OFS_STATUS, 32'h0);
		check("repeat done", {16'h0, rd[15:0]}, 32'h0);
		apb(1'b1, `OAD_OFS_OPERAND, 32'h2);
		exp_q.push_back({1'b0, 48'h0});
		run(16'h4B11);
		for (int k = 0; k < 3; k++) exp_q.push_back({1'b1, 16'h0, 32'h9});
		run(16'hCC09);
		repeat (5) @(posedge pclk);
		check("queue empty", 32'(exp_q.size()), 32'h0);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_sim();
	end
endmodule // tb_oad_decode
